// ### srr_host_model.sv
// Host controller model that reaches the status bank through its register port
`timescale 1ns/1ps
module srr_host_model
   import srr_pkg::*;
(
   input wire logic clock,      // System clock
   output srr_req_t req_out,    // Register access request
   input wire srr_rsp_t rsp_in, // Register read answer
   input wire logic srq_in      // Service request from the device
);
   // ==========================================================
   // Idle bus
   initial
   begin
      req_out = '{rd: 1'b0, wr: 1'b0, idx: 3'h0, data: 16'h5a5a};
   end

   // Idle data is inverted so a stale value never passes for a live one
   task automatic release_bus;
      req_out.rd = 1'b0;
      req_out.wr = 1'b0;
      req_out.data = ~req_out.data;
   endtask : release_bus

   // ==========================================================
   // Register cycles
   task automatic reg_write(input logic [2:0] idx, input logic [15:0] v);
      @(posedge clock);
      #1;
      req_out = '{rd: 1'b0, wr: 1'b1, idx: idx, data: v};
      @(posedge clock);
      #1;
      release_bus();
   endtask : reg_write

   // Answer is taken one edge after the request; no valid gives unknown data
   task automatic reg_read(input logic [2:0] idx, output logic [15:0] d);
      @(posedge clock);
      #1;
      req_out = '{rd: 1'b1, wr: 1'b0, idx: idx, data: req_out.data};
      @(posedge clock);
      #1;
      d = (rsp_in.valid === 1'b1) ? rsp_in.data : 16'hxxxx;
      release_bus();
   endtask : reg_read

   // ==========================================================
   // Service handling
   // acknowledge by reading
   task automatic ack_events;
      logic [15:0] junk;
      reg_read(SRR_IDX_OPER_EVENT, junk);
      reg_read(SRR_IDX_QUES_EVENT, junk);
   endtask : ack_events

   // Bounded wait, so a missing request cannot hang the host
   task automatic wait_srq(output logic seen);
      seen = 1'b0;
      for (int i = 0; i < 8 && seen !== 1'b1; i++)
      begin
         @(posedge clock);
         #1;
         seen = srq_in;
      end
   endtask : wait_srq
endmodule : srr_host_model

// ### srr_pkg.sv
// Package of constants and carrier types for the status reporting registers
package srr_pkg;

   // ==========================================================
   // Register indices on the register access port
   localparam logic [2:0] SRR_IDX_OPER_COND = 3'h0;
   localparam logic [2:0] SRR_IDX_OPER_EVENT = 3'h1;
   localparam logic [2:0] SRR_IDX_OPER_ENABLE = 3'h2;
   localparam logic [2:0] SRR_IDX_QUES_COND = 3'h3;
   localparam logic [2:0] SRR_IDX_QUES_EVENT = 3'h4;
   localparam logic [2:0] SRR_IDX_QUES_ENABLE = 3'h5;
   localparam logic [2:0] SRR_IDX_STATUS_BYTE = 3'h6;
   localparam logic [2:0] SRR_IDX_SRQ_ENABLE = 3'h7;

   // ==========================================================
   // Widths
   localparam int SRR_WIDE_W = 16;
   localparam int SRR_BYTE_W = 8;

   // ==========================================================
   // Operation register bit positions
   localparam int SRR_OP_SETTLING = 1;
   localparam int SRR_OP_TRIG_WAIT = 5;
   localparam int SRR_OP_TRANS_ARMED = 6;
   localparam int SRR_OP_CONST_VOLT = 8;
   localparam int SRR_OP_TRANS_DONE = 9;
   localparam int SRR_OP_CONST_CURR = 10;
   localparam int SRR_OP_SAMPLE_DONE = 11;
   localparam int SRR_OP_LIST_DONE = 12;
   localparam int SRR_OP_LIST_RUN = 14;
   localparam logic [15:0] SRR_OP_UNUSED_MASK = 16'ha09d;

   // ==========================================================
   // Questionable register bit positions
   localparam int SRR_QU_VOLT_MODE_ERR = 0;
   localparam int SRR_QU_CURR_MODE_ERR = 1;
   localparam int SRR_QU_THERMAL = 3;
   localparam int SRR_QU_SLAVE = 6;
   localparam int SRR_QU_VOLT_PROT = 12;
   localparam int SRR_QU_CURR_PROT = 13;
   localparam int SRR_QU_SINKING = 14;
   localparam logic [15:0] SRR_QU_UNUSED_MASK = 16'h8fb4;

   // ==========================================================
   // Status byte bit positions
   localparam int SRR_SB_QUES_ERRQ = 3;
   localparam int SRR_SB_MSG_AVAIL = 4;
   localparam int SRR_SB_STD_EVENT = 5;
   localparam int SRR_SB_REQ_SERVICE = 6;
   localparam int SRR_SB_OPER = 7;
   localparam logic [7:0] SRR_SB_RQS_MASK = 8'hbf;

   // ==========================================================
   // Reset values
   localparam logic [15:0] SRR_WIDE_RST = 16'h0000;
   localparam logic [7:0] SRR_BYTE_RST = 8'h00;

   // ==========================================================
   // Carrier types
   typedef struct packed {
      logic settling;          // Measurement system settling
      logic trig_enabled;      // Trigger system enabled
      logic trig_external;     // Trigger source is the external input
      logic trig_input;        // External trigger input level
      logic transient_armed;   // Transient function enabled
      logic const_volt;        // Constant voltage mode
      logic const_curr;        // Constant current mode
      logic transient_done;    // One-cycle pulse: transient completed
      logic sample_done;       // Sample completed
      logic list_done;         // One-cycle pulse: list completed
      logic list_running;      // Programmed list in progress
      logic thermal_err;       // Thermal error detected
      logic slave_err;         // Slave fault in master/slave setup
      logic volt_prot_err;     // Voltage protection error
      logic curr_prot_err;     // Current protection error
      logic ext_reference;     // External reference enabled
      logic sinking;           // Absorbing energy from the load
      logic err_queue_busy;    // Error/event queue holds an entry
      logic out_data_avail;    // Query response waiting in output buffer
      logic std_event_summary; // Summary from standard event status
   } srr_status_t;

   typedef struct packed {
      logic rd;          // Read strobe
      logic wr;          // Write strobe
      logic [2:0] idx;   // Register index
      logic [15:0] data; // Write data
   } srr_req_t;

   typedef struct packed {
      logic valid;       // Read data valid
      logic [15:0] data; // Read data
   } srr_rsp_t;

endpackage : srr_pkg

// ### srr_status_regs.sv
// Status reporting register bank with event latching and service request
`timescale 1ns/1ps
// ==========================================================
// Overview of operation
// - No queued error and no enabled questionable event keep status bit 3 at zero.
// - Status bit 4 is set while query response data awaits reading.
// - Operation and questionable registers are 16 bits; status byte 8 bits.
// - Each condition register has an event register and an enable mask.
// - A zero-to-one condition transition latches the matching event bit.
// - Reading an event register returns it and clears all bits except those set by an edge in that cycle.
// - Any enabled questionable event bit asserts status byte bit 3.
// - Status byte ANDed with request enable except bit 6 drives bit 6.
// - The service request line is asserted while status bit 6 is one.
// - Status bit 3 is set while the error/event queue holds an entry.
// - Operation bits 0, 2-4, 7, 13 and 15 always read zero.
// - Operation bit 1 is one while measurements are settling.
// - Operation bit 5 marks trigger wait; external low input holds it.
// - Operation bit 6 is one while the transient function is armed.
// - Operation bit 8 marks constant voltage, bit 10 constant current.
// - Transient and list completion bits 9, 12 appear only as events.
// - Operation bit 11 marks sample complete, bit 14 list running.
// - Questionable bit 0 marks current mode, bit 1 voltage mode.
// - Questionable bit 3 marks thermal error, bit 6 slave fault.
// - Questionable bit 12 voltage protection, bit 13 current protection.
// - With external reference, any protection error sets both bits 12, 13.
// - Questionable bit 14 marks sinking; other unused bits read zero.

module srr_status_regs
   import srr_pkg::*;
#(
   parameter int WIDE_W = SRR_WIDE_W,
   parameter int BYTE_W = SRR_BYTE_W
)
(
   input wire logic clock,                     // 200 MHz system clock
   input wire logic rst_n,                     // Synchronous reset, active low
   input wire srr_status_t status_in,          // Instrument state inputs
   input wire srr_req_t req_in,                // Register access request
   output srr_rsp_t rsp_out,                   // Register read answer
   output logic [BYTE_W-1:0] status_byte_out,  // Serial poll response byte
   output logic srq_out                        // Service request to controller
);

   // ==========================================================
   // Helpers
   function automatic logic [15:0] rise_of(input logic [15:0] cur, input logic [15:0] prev);
      rise_of = cur & ~prev;
   endfunction : rise_of

   function automatic logic summary_of(input logic [15:0] evt, input logic [15:0] en);
      summary_of = |(evt & en);
   endfunction : summary_of

   // ==========================================================
   // State
   logic trig_hold_r;
   logic [WIDE_W-1:0] oper_prev_r;
   logic [WIDE_W-1:0] ques_prev_r;
   logic [WIDE_W-1:0] oper_event_r;
   logic [WIDE_W-1:0] ques_event_r;
   logic [WIDE_W-1:0] oper_enable_r;
   logic [WIDE_W-1:0] ques_enable_r;
   logic [BYTE_W-1:0] srq_enable_r;
   logic [BYTE_W-1:0] status_byte_r;
   logic srq_r;
   srr_rsp_t rsp_r;

   logic trig_hold_nxt;
   logic [WIDE_W-1:0] oper_event_nxt;
   logic [WIDE_W-1:0] ques_event_nxt;
   logic [BYTE_W-1:0] status_byte_nxt;
   srr_rsp_t rsp_nxt;

   // ==========================================================
   // Trigger wait flag
   wire trig_low_ext = status_in.trig_external & ~status_in.trig_input;
   wire trigger_wait_flag = status_in.trig_enabled | trig_hold_r;
   assign trig_hold_nxt = trig_low_ext & (trigger_wait_flag | trig_hold_r);

   // ==========================================================
   // Operation condition register
   logic [WIDE_W-1:0] oper_cond;
   always_comb
   begin
      oper_cond = SRR_WIDE_RST;
      oper_cond[SRR_OP_SETTLING] = status_in.settling;
      oper_cond[SRR_OP_TRIG_WAIT] = trigger_wait_flag;
      oper_cond[SRR_OP_TRANS_ARMED] = status_in.transient_armed;
      oper_cond[SRR_OP_CONST_VOLT] = status_in.const_volt;
      oper_cond[SRR_OP_CONST_CURR] = status_in.const_curr;
      oper_cond[SRR_OP_SAMPLE_DONE] = status_in.sample_done;
      oper_cond[SRR_OP_LIST_RUN] = status_in.list_running;
   end

   // ==========================================================
   // Questionable condition register
   wire any_prot = status_in.volt_prot_err | status_in.curr_prot_err;
   wire both_prot = status_in.ext_reference & any_prot;
   logic [WIDE_W-1:0] ques_cond;
   always_comb
   begin
      ques_cond = SRR_WIDE_RST;
      ques_cond[SRR_QU_VOLT_MODE_ERR] = status_in.const_curr;
      ques_cond[SRR_QU_CURR_MODE_ERR] = status_in.const_volt;
      ques_cond[SRR_QU_THERMAL] = status_in.thermal_err;
      ques_cond[SRR_QU_SLAVE] = status_in.slave_err;
      ques_cond[SRR_QU_VOLT_PROT] = status_in.volt_prot_err | both_prot;
      ques_cond[SRR_QU_CURR_PROT] = status_in.curr_prot_err | both_prot;
      ques_cond[SRR_QU_SINKING] = status_in.sinking;
   end

   // ==========================================================
   // Event latching
   // Completion pulses enter the event register directly since their
   // condition bits never read as one.
   logic [WIDE_W-1:0] oper_pulses;
   always_comb
   begin
      oper_pulses = SRR_WIDE_RST;
      oper_pulses[SRR_OP_TRANS_DONE] = status_in.transient_done;
      oper_pulses[SRR_OP_LIST_DONE] = status_in.list_done;
   end

   wire [WIDE_W-1:0] oper_rise = rise_of(oper_cond, oper_prev_r) | oper_pulses;
   wire [WIDE_W-1:0] ques_rise = rise_of(ques_cond, ques_prev_r);

   wire rd_oper_event = req_in.rd & (req_in.idx == SRR_IDX_OPER_EVENT);
   wire rd_ques_event = req_in.rd & (req_in.idx == SRR_IDX_QUES_EVENT);

   // host acknowledges by reading
   // An edge in the reading cycle survives the clear so no event is lost.
   assign oper_event_nxt = (rd_oper_event ? SRR_WIDE_RST : oper_event_r) | oper_rise;
   assign ques_event_nxt = (rd_ques_event ? SRR_WIDE_RST : ques_event_r) | ques_rise;

   // ==========================================================
   // Status byte and service request
   // enable masks gate summaries
   wire oper_summary = summary_of(oper_event_r, oper_enable_r);
   wire ques_summary = summary_of(ques_event_r, ques_enable_r);

   logic [BYTE_W-1:0] sb_base;
   always_comb
   begin
      sb_base = SRR_BYTE_RST;
      sb_base[SRR_SB_QUES_ERRQ] = ques_summary | status_in.err_queue_busy;
      sb_base[SRR_SB_MSG_AVAIL] = status_in.out_data_avail;
      sb_base[SRR_SB_STD_EVENT] = status_in.std_event_summary;
      sb_base[SRR_SB_OPER] = oper_summary;
   end

   wire req_service = |(sb_base & srq_enable_r & SRR_SB_RQS_MASK);
   always_comb
   begin
      status_byte_nxt = sb_base;
      status_byte_nxt[SRR_SB_REQ_SERVICE] = req_service;
   end

   // ==========================================================
   // Register read path
   // register widths
   logic [WIDE_W-1:0] rd_mux;
   always_comb
   begin
      case (req_in.idx)
         SRR_IDX_OPER_COND: rd_mux = oper_cond;
         SRR_IDX_OPER_EVENT: rd_mux = oper_event_r;
         SRR_IDX_OPER_ENABLE: rd_mux = oper_enable_r;
         SRR_IDX_QUES_COND: rd_mux = ques_cond;
         SRR_IDX_QUES_EVENT: rd_mux = ques_event_r;
         SRR_IDX_QUES_ENABLE: rd_mux = ques_enable_r;
         SRR_IDX_STATUS_BYTE: rd_mux = {8'h00, status_byte_r};
         SRR_IDX_SRQ_ENABLE: rd_mux = {8'h00, srq_enable_r};
         default: rd_mux = SRR_WIDE_RST;
      endcase
   end

   assign rsp_nxt = '{valid: req_in.rd, data: (req_in.rd ? rd_mux : SRR_WIDE_RST)};

   wire wr_oper_en = req_in.wr & (req_in.idx == SRR_IDX_OPER_ENABLE);
   wire wr_ques_en = req_in.wr & (req_in.idx == SRR_IDX_QUES_ENABLE);
   wire wr_srq_en = req_in.wr & (req_in.idx == SRR_IDX_SRQ_ENABLE);

   // ==========================================================
   // Flip-flops
   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         trig_hold_r <= 1'b0;
         oper_prev_r <= SRR_WIDE_RST;
         ques_prev_r <= SRR_WIDE_RST;
         oper_event_r <= SRR_WIDE_RST;
         ques_event_r <= SRR_WIDE_RST;
      end
      else
      begin
         trig_hold_r <= trig_hold_nxt;
         oper_prev_r <= oper_cond;
         ques_prev_r <= ques_cond;
         oper_event_r <= oper_event_nxt;
         ques_event_r <= ques_event_nxt;
      end
   end

   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         oper_enable_r <= SRR_WIDE_RST;
         ques_enable_r <= SRR_WIDE_RST;
         srq_enable_r <= SRR_BYTE_RST;
      end
      else
      begin
         if (wr_oper_en)
            oper_enable_r <= req_in.data;
         if (wr_ques_en)
            ques_enable_r <= req_in.data;
         if (wr_srq_en)
            srq_enable_r <= req_in.data[BYTE_W-1:0];
      end
   end

   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         status_byte_r <= SRR_BYTE_RST;
         srq_r <= 1'b0;
         rsp_r <= '0;
      end
      else
      begin
         status_byte_r <= status_byte_nxt;
         srq_r <= status_byte_nxt[SRR_SB_REQ_SERVICE];
         rsp_r <= rsp_nxt;
      end
   end

   assign status_byte_out = status_byte_r;
   assign srq_out = srq_r;
   assign rsp_out = rsp_r;

   // ==========================================================
   // Assertions
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);

   sequence oper_evt_read_s;
      rd_oper_event && (oper_rise == 16'h0000);
   endsequence

   sequence oper_evt_cleared_s;
      (oper_event_r == 16'h0000) && rsp_out.valid;
   endsequence

   srq_tracks_bit6_a: assert property (
      srq_out == |(status_byte_out & $past(srq_enable_r) & SRR_SB_RQS_MASK))
      else $error("service request differs from enabled status bits");

   ques_edge_latch_a: assert property ((ques_rise != 16'h0000) |=>
      ((ques_event_r & $past(ques_rise)) == $past(ques_rise)))
      else $error("questionable rising edge not latched");

   event_read_clear_a: assert property (oper_evt_read_s |=> oper_evt_cleared_s)
      else $error("operation event not cleared by read");

   read_returns_event_a: assert property (rd_ques_event |=>
      (rsp_out.data == $past(ques_event_r)))
      else $error("event read returned wrong contents");

   ques_summary_bit_a: assert property (ques_summary |=> status_byte_out[SRR_SB_QUES_ERRQ])
      else $error("questionable summary missing from bit 3");

   msg_avail_bit_a: assert property ($rose(status_in.out_data_avail) |=>
      status_byte_out[SRR_SB_MSG_AVAIL])
      else $error("message available bit not set");

   clear_bit3_a: assert property ((!ques_summary && !status_in.err_queue_busy) |=>
      !status_byte_out[SRR_SB_QUES_ERRQ])
      else $error("bit 3 set with no error or summary");

   rqs_from_mask_a: assert property ((|(sb_base & srq_enable_r & SRR_SB_RQS_MASK))
      |=> srq_out ##0 status_byte_out[SRR_SB_REQ_SERVICE])
      else $error("request service not raised");

   oper_unused_zero_a: assert property ((oper_cond & SRR_OP_UNUSED_MASK) == 16'h0000)
      else $error("unused operation bit set");

   ques_unused_zero_a: assert property ((ques_cond & SRR_QU_UNUSED_MASK) == 16'h0000)
      else $error("unused questionable bit set");

   ext_ref_prot_a: assert property (both_prot |-> (ques_cond[13:12] == 2'b11))
      else $error("protection bits not both set");

   trans_done_event_a: assert property (status_in.transient_done |=>
      oper_event_r[SRR_OP_TRANS_DONE] && !oper_cond[SRR_OP_TRANS_DONE])
      else $error("transient completion not reported as event");

   trig_hold_a: assert property ((oper_cond[SRR_OP_TRIG_WAIT] && trig_low_ext) |=>
      (oper_cond[SRR_OP_TRIG_WAIT] || !trig_low_ext))
      else $error("trigger wait dropped while input low");

   err_queue_bit3_a: assert property (status_in.err_queue_busy |=>
      status_byte_out[SRR_SB_QUES_ERRQ])
      else $error("bit 3 not set for queued error");

   list_done_event_a: assert property (status_in.list_done |=>
      oper_event_r[SRR_OP_LIST_DONE] && !oper_cond[SRR_OP_LIST_DONE])
      else $error("list completion not reported as event");

   srq_falls_a: assert property (!req_service |=>
      (!srq_out && !status_byte_out[SRR_SB_REQ_SERVICE]))
      else $error("service request stayed up after sources cleared");

   mode_bits_a: assert property (
      ques_cond[1:0] == {status_in.const_volt, status_in.const_curr})
      else $error("mode error bits do not follow regulation mode");

   oper_mask_gate_a: assert property (((oper_event_r & oper_enable_r) == 16'h0000) |=>
      !status_byte_out[SRR_SB_OPER])
      else $error("masked operation event reached the summary");

endmodule : srr_status_regs

// ### status_reporting_registers_tb.sv
// Self-checking bench for the status reporting register bank
`timescale 1ns/1ps
module status_reporting_registers_tb;
   import srr_pkg::*;
   typedef struct {
      logic [19:0] m;
      logic [15:0] op;
      logic [15:0] qu;
      logic [7:0] sb;
   } srr_row_t;

   logic clock;
   logic rst_n;
   srr_status_t st;
   srr_req_t req;
   srr_rsp_t rsp;
   logic [7:0] sbyte;
   logic srq;
   logic [15:0] d;
   logic seen;
   int n_mismatch = 0;
   int checks_done = 0;
   int cycles = 0;
   // Status mask, operation and questionable conditions, status byte
   srr_row_t rows [19] = '{
      '{20'h80000, 16'h0002, 16'h0000, 8'h00}, '{20'h40000, 16'h0020, 16'h0000, 8'h00},
      '{20'h08000, 16'h0040, 16'h0000, 8'h00}, '{20'h04000, 16'h0100, 16'h0002, 8'h00},
      '{20'h02000, 16'h0400, 16'h0001, 8'h00}, '{20'h00800, 16'h0800, 16'h0000, 8'h00},
      '{20'h00200, 16'h4000, 16'h0000, 8'h00}, '{20'h00100, 16'h0000, 16'h0008, 8'h00},
      '{20'h00080, 16'h0000, 16'h0040, 8'h00}, '{20'h00040, 16'h0000, 16'h1000, 8'h00},
      '{20'h00020, 16'h0000, 16'h2000, 8'h00}, '{20'h00030, 16'h0000, 16'h3000, 8'h00},
      '{20'h00010, 16'h0000, 16'h0000, 8'h00}, '{20'h00008, 16'h0000, 16'h4000, 8'h00},
      '{20'h00004, 16'h0000, 16'h0000, 8'h08}, '{20'h00002, 16'h0000, 16'h0000, 8'h10},
      '{20'h00001, 16'h0000, 16'h0000, 8'h20}, '{20'h30000, 16'h0000, 16'h0000, 8'h00},
      '{20'hfebff, 16'h4d62, 16'h704b, 8'h38}
   };

   srr_status_regs srr_status_regs_inst (
      .clock(clock),
      .rst_n(rst_n),
      .status_in(st),
      .req_in(req),
      .rsp_out(rsp),
      .status_byte_out(sbyte),
      .srq_out(srq)
   );

   srr_host_model srr_host_model_inst (
      .clock(clock),
      .req_out(req),
      .rsp_in(rsp),
      .srq_in(srq)
   );

   // ==========================================================
   // Clock and watchdog
   initial
   begin
      clock = 1'b0;
      forever #2.5 clock = ~clock;
   end

   always @(posedge clock)
   begin
      cycles <= cycles + 1;
      if (cycles == 3000)
      begin
         n_mismatch++;
         $display("MISMATCH t=%0t run timed out", $time);
         test_done();
      end
   end

   // ==========================================================
   // Helpers
   task automatic test_done;
      $display("checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : test_done

   task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
      checks_done++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("MISMATCH t=%0t %s seen %h expected %h", $time, what, got, exp);
      end
   endtask : check

   task automatic wait_n(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask : wait_n

   task automatic drive(input logic [19:0] m);
      @(posedge clock);
      #1;
      st = srr_status_t'(m);
   endtask : drive

   task automatic rd_chk(input logic [2:0] idx, input logic [15:0] exp, input string what);
      srr_host_model_inst.reg_read(idx, d);
      check(d, exp, what);
   endtask : rd_chk

   task automatic wr(input logic [2:0] idx, input logic [15:0] v);
      srr_host_model_inst.reg_write(idx, v);
   endtask : wr

   task automatic pins(input logic [7:0] sb, input logic rq, input string what);
      check({8'h00, sbyte}, {8'h00, sb}, what);
      check({15'h0000, srq}, {15'h0000, rq}, what);
   endtask : pins

   // ==========================================================
   // Main sequence
   initial
   begin
      rst_n = 1'b0;
      st = '0;
      wait_n(3);
      rst_n = 1'b1;
      // Writes to read-only places must leave them untouched
      for (int i = 0; i < 7; i++)
         if (i != 2 && i != 5)
            wr(i[2:0], 16'hffff);
      for (int i = 0; i < 8; i++)
         rd_chk(i[2:0], 16'h0000, "reset or read-only value");
      pins(8'h00, 1'b0, "reset pins");
      $display("test reset done");

      foreach (rows[k])
      begin
         drive(rows[k].m);
         wait_n(3);
         rd_chk(SRR_IDX_OPER_COND, rows[k].op, "oper cond");
         rd_chk(SRR_IDX_QUES_COND, rows[k].qu, "ques cond");
         rd_chk(SRR_IDX_STATUS_BYTE, {8'h00, rows[k].sb}, "status byte");
      end
      $display("test table done");

      drive(20'h00000);
      wait_n(2);
      srr_host_model_inst.ack_events();
      wr(SRR_IDX_QUES_ENABLE, 16'h0001);
      wr(SRR_IDX_SRQ_ENABLE, 16'h0008);
      rd_chk(SRR_IDX_QUES_ENABLE, 16'h0001, "ques enable");
      rd_chk(SRR_IDX_SRQ_ENABLE, 16'h0008, "request enable");
      pins(8'h00, 1'b0, "quiet pins");
      drive(20'h02000);
      wait_n(3);
      pins(8'h48, 1'b1, "ques summary request");
      rd_chk(SRR_IDX_QUES_EVENT, 16'h0001, "ques event");
      rd_chk(SRR_IDX_QUES_EVENT, 16'h0000, "event cleared by read");
      wait_n(2);
      pins(8'h00, 1'b0, "summary falls");
      $display("test ques events done");

      // Oper event still holds the constant current rise, masked off here
      wr(SRR_IDX_OPER_ENABLE, 16'h1200);
      wr(SRR_IDX_SRQ_ENABLE, 16'h0080);
      wait_n(2);
      pins(8'h00, 1'b0, "masked event");
      drive(20'h01000);
      drive(20'h00000);
      srr_host_model_inst.wait_srq(seen);
      check({15'h0000, seen}, 16'h0001, "request seen");
      wait_n(1);
      pins(8'hc0, 1'b1, "oper summary request");
      rd_chk(SRR_IDX_OPER_COND, 16'h0000, "done absent from cond");
      rd_chk(SRR_IDX_OPER_EVENT, 16'h0600, "transient event");
      drive(20'h00400);
      drive(20'h00000);
      wait_n(2);
      rd_chk(SRR_IDX_OPER_EVENT, 16'h1000, "list event");
      $display("test oper events done");

      drive(20'h60000);
      wait_n(2);
      rd_chk(SRR_IDX_OPER_COND, 16'h0020, "trigger wait");
      drive(20'h20000);
      wait_n(2);
      rd_chk(SRR_IDX_OPER_COND, 16'h0020, "trigger held low");
      drive(20'h30000);
      wait_n(2);
      rd_chk(SRR_IDX_OPER_COND, 16'h0000, "trigger released");
      $display("test trigger done");

      wr(SRR_IDX_SRQ_ENABLE, 16'h0040);
      drive(20'h00002);
      wait_n(3);
      pins(8'h10, 1'b0, "bit 6 not self enabling");
      wr(SRR_IDX_SRQ_ENABLE, 16'h0050);
      wait_n(3);
      pins(8'h50, 1'b1, "data waiting request");
      $display("test request mask done");

      rst_n = 1'b0;
      wait_n(2);
      rst_n = 1'b1;
      wait_n(2);
      rd_chk(SRR_IDX_SRQ_ENABLE, 16'h0000, "enable after reset");
      rd_chk(SRR_IDX_OPER_ENABLE, 16'h0000, "oper enable after reset");
      pins(8'h10, 1'b0, "pins after reset");
      $display("test mid-run reset done");
      test_done();
   end
endmodule : status_reporting_registers_tb
